/* pdasc_params.svh */
// Constants for the paged data address and stack check block
// Behaviour
// [R1] Paged write joins write page above EA
// [R2] Paged read joins read page above EA
// [R3] Pointer wrap never changes page registers
// [R4] Paged writes finish in one cycle
// [R5] Paged read one extra cycle; repeat rule
// [R6] Read-modify-write uses read page both ways
// [R7] Addresses below 8000h ignore page registers
// [R8] Nonzero page selects consecutive 32K region
// [R9] Window access with page zero traps
// [R10] Stack grows up: push post-increments, pop pre-decrements
// [R11] Call push zero-fills upper byte
// [R12] Exception push inserts status low byte
// [R13] Limit unreset, bit zero reads zero
// [R14] Push beyond limit traps, equal does not
// [R15] Stack address below 0800h traps
// [R16] Separate one-cycle traps, access suppressed
// [R17] Limit write not forwarded to compare
`ifndef PDASC_PARAMS_SVH
`define PDASC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PDASC_OFF_RPAGE   4'h0
`define PDASC_OFF_WPAGE   4'h1
`define PDASC_OFF_LIMIT   4'h2
`define PDASC_OFF_SP      4'h3
`define PDASC_OFF_STATUS  4'h4
`define PDASC_OFF_CLEAR   4'h5
`define PDASC_OFF_ENABLE  4'h6

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define PDASC_RST_RPAGE   10'h001
`define PDASC_RST_WPAGE   9'h001
`define PDASC_RST_SP      16'h0800
`define PDASC_RPAGE_PSV   9
`define PDASC_EA_WIN      15
`define PDASC_EVT_ADDR    0
`define PDASC_EVT_STACK   1

// ----------------------------------------------------------------
// Stack and timing
// ----------------------------------------------------------------
`define PDASC_SFR_TOP     16'h0800
`define PDASC_WORD_STEP   16'h0002
`define PDASC_EXTRA_RD    2'h1
`define PDASC_EXTRA_RPT   2'h2
`define PDASC_RPT_SLOW    2'h2

`endif

/* pdasc_pkg.sv */
// Types for the paged data address and stack check block
package pdasc_pkg;

  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_WRITE    = 3'h1,
    OP_RMW_WB   = 3'h2,
    OP_PUSH     = 3'h3,
    OP_PUSH_CALL = 3'h4,
    OP_PUSH_EXC = 3'h5,
    OP_POP      = 3'h6
  } pdasc_op_t;

  typedef struct packed {
    logic      valid;
    pdasc_op_t op;
    logic      rpt;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic [7:0]  pcUpper;
    logic [7:0]  statusLow;
  } pdasc_req_t;

  typedef struct packed {
    logic        rdEn;
    logic        wrEn;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pdasc_mem_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_LAST = 2'b11
  } pdasc_state_t;

endpackage

/* pdasc_page_map.sv */
// Page window address extension for one page register
`timescale 1ns/100ps
`include "pdasc_params.svh"
module pdasc_page_map #(
  parameter int PAGE_W = 9,
  parameter int EA_W   = 16
) (
  // Effective address and page
  input  wire logic [EA_W-1:0]        ea,
  input  wire logic [PAGE_W-1:0]      page,
  // Mapped result
  output      logic [PAGE_W+EA_W-2:0] addr,
  output      logic                   invalid
);

  if (PAGE_W < 1 || EA_W < 2)
  begin : g_badWidth
    $error("pdasc_page_map: unsupported widths");
  end

  logic windowOn;

  assign windowOn = ea[EA_W-1];
  // Window: page above low bits; below: direct map [R1] [R2] [R7] [R8]
  assign addr = windowOn ? {page, ea[EA_W-2:0]} : {{(PAGE_W-1){1'b0}}, ea};
  // Page zero inside window is illegal [R9]
  assign invalid = windowOn && (page == '0);

endmodule

/* pdasc_top.sv */
// Paged data address generation and software stack checking
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "pdasc_params.svh"
module pdasc_top (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Register port
  input  wire logic [3:0]          regAddr,
  input  wire logic [15:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output      logic [15:0]         regRdata,
  // Execution unit request
  input  wire pdasc_pkg::pdasc_req_t req,
  output      logic                cpuStall,
  // Data memory side
  output      pdasc_pkg::pdasc_mem_t memOut,
  // Exception unit
  output      logic                addrErrTrap,
  output      logic                stackErrTrap,
  output      logic                irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [9:0]  rpage_ff;
  logic [8:0]  wpage_ff;
  logic [15:0] limit_ff;
  logic [15:0] sp_ff;
  logic [1:0]  status_ff;
  logic [1:0]  enable_ff;
  logic [15:0] regRdata_ff;
  logic        irq_ff;
  logic        addrTrap_ff;
  logic        stackTrap_ff;
  logic        stall_ff;
  logic [1:0]  rptCnt_ff;
  pdasc_pkg::pdasc_mem_t   mem_ff;
  pdasc_pkg::pdasc_state_t state_ff;
  pdasc_pkg::pdasc_state_t nxt_state;

  // ----------------------------------------------------------------
  // Page mapping
  // ----------------------------------------------------------------
  logic [23:0] rdAddr;
  logic [23:0] wrAddr;
  logic        rdInvalid;
  logic        wrInvalid;

  pdasc_page_map #(
    .PAGE_W (9),
    .EA_W   (16)
  ) u_rd_map (
    .ea      (req.ea),
    .page    (rpage_ff[8:0]),
    .addr    (rdAddr),
    .invalid (rdInvalid)
  );

  pdasc_page_map #(
    .PAGE_W (9),
    .EA_W   (16)
  ) u_wr_map (
    .ea      (req.ea),
    .page    (wpage_ff),
    .addr    (wrAddr),
    .invalid (wrInvalid)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic        taken;
  logic        isPush;
  logic        isPop;
  logic        isStack;
  logic        isRead;
  logic        useRdPage;
  logic        pagedRead;
  logic [15:0] spDec;
  logic [15:0] spInc;
  logic [15:0] stackAddr;
  logic [15:0] limitEff;
  logic        overflow;
  logic        underflow;
  logic        addrBad;
  logic        stackBad;
  logic        accessOk;
  logic [23:0] mapAddr;
  logic [15:0] pushData;
  logic [1:0]  extra;

  assign taken = req.valid && (state_ff == pdasc_pkg::ST_IDLE);

  always_comb
  begin
    isPush    = (req.op == pdasc_pkg::OP_PUSH) || (req.op == pdasc_pkg::OP_PUSH_CALL)
             || (req.op == pdasc_pkg::OP_PUSH_EXC);
    isPop     = (req.op == pdasc_pkg::OP_POP);
    isStack   = isPush || isPop;
    isRead    = (req.op == pdasc_pkg::OP_READ) || isPop;
    // Write-back of read-modify-write reuses read page [R6]
    useRdPage = (req.op == pdasc_pkg::OP_READ) || (req.op == pdasc_pkg::OP_RMW_WB);
    pagedRead = (req.op == pdasc_pkg::OP_READ) && req.ea[`PDASC_EA_WIN];
    // Pop pre-decrements, push uses pointer as is [R10]
    spDec     = sp_ff - `PDASC_WORD_STEP;
    spInc     = sp_ff + `PDASC_WORD_STEP;
    stackAddr = isPop ? spDec : sp_ff;
    // Limit bit zero always acts as zero; no bypass of a fresh write [R13] [R17]
    limitEff  = {limit_ff[15:1], 1'b0};
    // Push at limit passes, one beyond traps [R14]
    overflow  = isPush && (sp_ff > limitEff);
    underflow = isStack && (stackAddr < `PDASC_SFR_TOP);        // [R15]
    stackBad  = overflow || underflow;
    if (isStack)
      addrBad = 1'b0;
    else if (useRdPage)
      addrBad = rdInvalid || (req.ea[`PDASC_EA_WIN] && rpage_ff[`PDASC_RPAGE_PSV]); // [R2] [R9]
    else
      addrBad = wrInvalid;                                       // [R9]
    accessOk  = !addrBad && !stackBad;
    if (isStack)
      mapAddr = {8'h00, stackAddr};
    else if (useRdPage)
      mapAddr = rdAddr;                                          // [R2] [R6]
    else
      mapAddr = wrAddr;                                          // [R1]
    unique case (req.op)
      pdasc_pkg::OP_PUSH_CALL: pushData = {8'h00, req.pcUpper};          // [R11]
      pdasc_pkg::OP_PUSH_EXC:  pushData = {req.statusLow, req.pcUpper};  // [R12]
      default:                 pushData = req.wdata;
    endcase
    // Read wait: one extra, or repeat pattern [R5]
    if (!req.rpt)
      extra = `PDASC_EXTRA_RD;
    else if (rptCnt_ff < `PDASC_RPT_SLOW)
      extra = `PDASC_EXTRA_RPT;
    else
      extra = 2'h0;
  end

  // ----------------------------------------------------------------
  // Read wait sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      pdasc_pkg::ST_IDLE:
      begin
        if (taken && pagedRead && accessOk)
        begin
          if (extra == `PDASC_EXTRA_RPT)
            nxt_state = pdasc_pkg::ST_WAIT;
          else if (extra == `PDASC_EXTRA_RD)
            nxt_state = pdasc_pkg::ST_LAST;                      // [R5]
        end
      end
      pdasc_pkg::ST_WAIT: nxt_state = pdasc_pkg::ST_LAST;
      pdasc_pkg::ST_LAST: nxt_state = pdasc_pkg::ST_IDLE;
      default:            nxt_state = pdasc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_ff <= pdasc_pkg::ST_IDLE;
      stall_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      // Writes never stall [R4]
      stall_ff <= (nxt_state != pdasc_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rptCnt_ff <= 2'h0;
    else if (taken && !req.rpt)
      rptCnt_ff <= 2'h0;
    else if (taken && pagedRead && accessOk && rptCnt_ff < `PDASC_RPT_SLOW)
      rptCnt_ff <= rptCnt_ff + 2'h1;                             // [R5]
  end

  // ----------------------------------------------------------------
  // Memory access and traps
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      mem_ff <= '0;
    else
    begin
      // Offending access is dropped [R16]
      mem_ff.rdEn <= taken && isRead && accessOk;
      mem_ff.wrEn <= taken && !isRead && accessOk;               // [R4]
      if (taken)
      begin
        mem_ff.addr  <= mapAddr;
        mem_ff.wdata <= pushData;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      addrTrap_ff  <= 1'b0;
      stackTrap_ff <= 1'b0;
    end
    else
    begin
      addrTrap_ff  <= taken && addrBad;                          // [R9] [R16]
      stackTrap_ff <= taken && stackBad;                         // [R14] [R15] [R16]
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer and page registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      sp_ff <= `PDASC_RST_SP;
    else if (regWr && regAddr == `PDASC_OFF_SP)
      sp_ff <= {regWdata[15:1], 1'b0};
    else if (taken && accessOk && isPush)
      sp_ff <= spInc;                                            // [R10]
    else if (taken && accessOk && isPop)
      sp_ff <= spDec;                                            // [R10]
  end

  // No reset: limit starts undefined [R13]
  always_ff @(posedge clk_sys)
  begin
    if (regWr && regAddr == `PDASC_OFF_LIMIT)
      limit_ff <= {regWdata[15:1], 1'b0};                        // [R13]
  end

  // Only software moves pages, never pointer wrap [R3]
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rpage_ff <= `PDASC_RST_RPAGE;
      wpage_ff <= `PDASC_RST_WPAGE;
    end
    else if (regWr)
    begin
      if (regAddr == `PDASC_OFF_RPAGE)
        rpage_ff <= regWdata[9:0];
      if (regAddr == `PDASC_OFF_WPAGE)
        wpage_ff <= regWdata[8:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [1:0] events;
  logic [1:0] clearBits;
  logic [1:0] nxt_status;

  always_comb
  begin
    events = 2'h0;
    events[`PDASC_EVT_ADDR]  = taken && addrBad;
    events[`PDASC_EVT_STACK] = taken && stackBad;
    clearBits  = (regWr && regAddr == `PDASC_OFF_CLEAR) ? regWdata[1:0] : 2'h0;
    // Set beats a simultaneous clear
    nxt_status = (status_ff & ~clearBits) | events;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      status_ff <= 2'h0;
      enable_ff <= 2'h0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      if (regWr && regAddr == `PDASC_OFF_ENABLE)
        enable_ff <= regWdata[1:0];
      irq_ff <= |(status_ff & enable_ff);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      regRdata_ff <= 16'h0000;
    else if (regRd)
    begin
      unique case (regAddr)
        `PDASC_OFF_RPAGE:  regRdata_ff <= {6'h00, rpage_ff};
        `PDASC_OFF_WPAGE:  regRdata_ff <= {7'h00, wpage_ff};
        `PDASC_OFF_LIMIT:  regRdata_ff <= limitEff;              // [R13]
        `PDASC_OFF_SP:     regRdata_ff <= sp_ff;
        `PDASC_OFF_STATUS: regRdata_ff <= {14'h0000, status_ff};
        `PDASC_OFF_ENABLE: regRdata_ff <= {14'h0000, enable_ff};
        default:           regRdata_ff <= 16'h0000;
      endcase
    end
    else
      regRdata_ff <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata     = regRdata_ff;
  assign cpuStall     = stall_ff;
  assign memOut       = mem_ff;
  assign addrErrTrap  = addrTrap_ff;
  assign stackErrTrap = stackTrap_ff;
  assign irq          = irq_ff;

endmodule

/* pdasc_chk.sv */
// Port checker for the paged address and stack check block
`timescale 1ns/100ps
module pdasc_chk (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  // Watched ports
  input wire pdasc_pkg::pdasc_req_t req,
  input wire logic                  cpuStall,
  input wire pdasc_pkg::pdasc_mem_t memOut,
  input wire logic                  addrErrTrap,
  input wire logic                  stackErrTrap
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire tk = req.valid && !cpuStall;
  wire wr = tk && req.op == pdasc_pkg::OP_WRITE;
  wire st = tk && req.op inside {pdasc_pkg::OP_PUSH, pdasc_pkg::OP_PUSH_CALL,
                                 pdasc_pkg::OP_PUSH_EXC, pdasc_pkg::OP_POP};
  wire ps = st && req.op != pdasc_pkg::OP_POP;
  sequence s_stall1;
    cpuStall ##1 !cpuStall;
  endsequence
  property p_near;
    wr && !req.ea[15] |=> memOut.wrEn && memOut.addr == {8'h00, $past(req.ea)};
  endproperty
  property p_wfast;
    wr && req.ea[15] |=> !cpuStall;
  endproperty
  property p_rslow;
    tk && req.op == pdasc_pkg::OP_READ && req.ea[15] && !req.rpt |=> s_stall1 or addrErrTrap;
  endproperty
  property p_aesup;
    addrErrTrap |-> !memOut.rdEn && !memOut.wrEn;
  endproperty
  property p_sesup;
    stackErrTrap |-> !memOut.rdEn && !memOut.wrEn;
  endproperty
  property p_call;
    tk && req.op == pdasc_pkg::OP_PUSH_CALL |=> stackErrTrap ||
      (memOut.wrEn && memOut.wdata == {8'h00, $past(req.pcUpper)});
  endproperty
  property p_exc;
    tk && req.op == pdasc_pkg::OP_PUSH_EXC |=> stackErrTrap ||
      (memOut.wrEn && memOut.wdata == {$past(req.statusLow), $past(req.pcUpper)});
  endproperty
  property p_stk;
    ps |=> stackErrTrap || (memOut.wrEn && memOut.addr[23:16] == 8'h00 && !memOut.addr[0]);
  endproperty
  property p_floor;
    st |=> !(memOut.rdEn || memOut.wrEn) || memOut.addr >= 24'h000800;
  endproperty
  a_near: assert property (p_near) else $error("near write address wrong");
  a_wfast: assert property (p_wfast) else $error("window write stalled");
  a_rslow: assert property (p_rslow) else $error("window read stall wrong");
  a_aesup: assert property (p_aesup) else $error("access beside address trap");
  a_sesup: assert property (p_sesup) else $error("access beside stack trap");
  a_call: assert property (p_call) else $error("call push upper byte wrong");
  a_exc: assert property (p_exc) else $error("exception push word wrong");
  a_stk: assert property (p_stk) else $error("push address not aligned");
  a_floor: assert property (p_floor) else $error("stack access below floor");
endmodule
bind pdasc_top pdasc_chk chk_u (.clk_sys(clk_sys), .rstn(rstn), .req(req),
  .cpuStall(cpuStall), .memOut(memOut), .addrErrTrap(addrErrTrap),
  .stackErrTrap(stackErrTrap));

/* pdasc_mem_model.sv */
// Data memory model recording the block's traffic
`timescale 1ns/100ps
module pdasc_mem_model (
  // Clock
  input  wire logic                  clk_sys,
  // Memory bus
  input  wire pdasc_pkg::pdasc_mem_t memIn,
  // Last transfer
  output      logic [23:0]           lastAddr,
  output      logic [15:0]           lastData
);
  logic [15:0] mem [256];
  always @(posedge clk_sys)
  begin
    if (memIn.wrEn)
    begin
      mem[memIn.addr[8:1]] <= memIn.wdata;
      lastAddr <= memIn.addr;
      lastData <= memIn.wdata;
    end
    if (memIn.rdEn)
    begin
      lastAddr <= memIn.addr;
      lastData <= mem[memIn.addr[8:1]];
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the paged address and stack check block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic                  clk_sys, rstn, regWr, regRd, cpuStall, aeT, seT, irq;
  logic [3:0]            regAddr, flg;
  logic [15:0]           regWdata, regRdata, rdv, lastData;
  logic [23:0]           lastAddr;
  pdasc_pkg::pdasc_req_t req;
  pdasc_pkg::pdasc_mem_t memOut;
  int                    err_count = 0, n_tests = 0, nst, cyc = 0;
  logic [3:0]            ra [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'hf};
  logic [15:0]           rv [6] = '{16'h0001, 16'h0001, 16'h0800, 16'h0, 16'h0, 16'h0};
  logic [8:0]            pg [3] = '{9'h001, 9'h002, 9'h1ff};
  logic [15:0]           pd [3] = '{16'h5a7f, 16'h007f, 16'h1111};
  pdasc_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .req(req), .cpuStall(cpuStall),
    .memOut(memOut), .addrErrTrap(aeT), .stackErrTrap(seT), .irq(irq));
  pdasc_mem_model mem_u (.clk_sys(clk_sys), .memIn(memOut), .lastAddr(lastAddr),
    .lastData(lastData));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    rdv = regRdata;
  endtask
  task rq(input pdasc_pkg::pdasc_op_t o, input logic [15:0] a, input logic [15:0] d,
          input logic r);
    @(posedge clk_sys);
    req.valid <= 1'b1;
    req.op <= o;
    req.ea <= a;
    req.wdata <= d;
    req.rpt <= r;
    @(posedge clk_sys);
    req.valid <= 1'b0;
    @(negedge clk_sys);
    flg = {memOut.rdEn, memOut.wrEn, aeT, seT};
    nst = 0;
    while (cpuStall === 1'b1 && nst < 4)
    begin
      @(negedge clk_sys);
      nst++;
    end
    @(negedge clk_sys);
  endtask
  task summarize();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0;
    req = '0;
    req.pcUpper = 8'h7f;
    req.statusLow = 8'h5a;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (ra[i])
    begin
      rd(ra[i]);
      `CHK(rdv, rv[i])
    end
    rq(pdasc_pkg::OP_WRITE, 16'h1234, 16'hbeef, 1'b0);
    `CHK({flg, lastAddr, lastData}, {4'b0100, 24'h001234, 16'hbeef})
    rq(pdasc_pkg::OP_READ, 16'h7ffe, 16'h0, 1'b0);
    `CHK({flg, lastAddr, nst[1:0]}, {4'b1000, 24'h007ffe, 2'h0})
    foreach (pg[i])
    begin
      wr(4'h1, {7'h00, pg[i]});
      wr(4'h0, {7'h00, pg[i]});
      rq(pdasc_pkg::OP_WRITE, 16'hc002, 16'h0, 1'b0);
      `CHK({flg, lastAddr, nst[1:0]}, {4'b0100, pg[i], 15'h4002, 2'h0})
      rq(pdasc_pkg::OP_READ, 16'hc002, 16'h0, 1'b0);
      `CHK({flg, lastAddr, nst[1:0]}, {4'b1000, pg[i], 15'h4002, 2'h1})
    end
    for (int i = 0; i < 3; i++)
    begin
      rq(pdasc_pkg::OP_READ, 16'h8004, 16'h0, 1'b1);
      `CHK(nst[1:0], (i < 2) ? 2'h2 : 2'h0)
    end
    rq(pdasc_pkg::OP_READ, 16'h8004, 16'h0, 1'b0);
    `CHK(nst[1:0], 2'h1)
    wr(4'h0, 16'h0003);
    wr(4'h1, 16'h0005);
    rq(pdasc_pkg::OP_RMW_WB, 16'h8010, 16'h00aa, 1'b0);
    `CHK({flg, lastAddr}, {4'b0100, 24'h018010})
    rq(pdasc_pkg::OP_WRITE, 16'hfffe, 16'h0, 1'b0);
    rq(pdasc_pkg::OP_WRITE, 16'h8000, 16'h0, 1'b0);
    rd(4'h1);
    `CHK({rdv, lastAddr}, {16'h0005, 24'h028000})
    rd(4'h0);
    `CHK(rdv, 16'h0003)
    wr(4'h6, 16'h0003);
    rd(4'h6);
    `CHK(rdv, 16'h0003)
    wr(4'h1, 16'h0000);
    rq(pdasc_pkg::OP_WRITE, 16'h8000, 16'h0, 1'b0);
    `CHK({flg, irq}, 5'b00101)
    rd(4'h4);
    `CHK(rdv, 16'h0001)
    wr(4'h5, 16'h0001);
    rd(4'h4);
    `CHK({rdv, irq}, {16'h0000, 1'b0})
    wr(4'h6, 16'h0000);
    wr(4'h0, 16'h0000);
    rq(pdasc_pkg::OP_READ, 16'h8000, 16'h0, 1'b0);
    `CHK({flg, irq}, 5'b00100)
    wr(4'h0, 16'h0201);
    rq(pdasc_pkg::OP_READ, 16'h8000, 16'h0, 1'b0);
    `CHK(flg, 4'b0010)
    wr(4'h5, 16'h0003);
    wr(4'h2, 16'h0805);
    rd(4'h2);
    `CHK(rdv, 16'h0804)
    rq(pdasc_pkg::OP_PUSH, 16'h0, 16'h1111, 1'b0);
    `CHK({flg, lastAddr, lastData}, {4'b0100, 24'h000800, 16'h1111})
    rq(pdasc_pkg::OP_PUSH_CALL, 16'h0, 16'h0, 1'b0);
    `CHK({flg, lastAddr, lastData}, {4'b0100, 24'h000802, 16'h007f})
    rq(pdasc_pkg::OP_PUSH_EXC, 16'h0, 16'h0, 1'b0);
    `CHK({flg, lastAddr, lastData}, {4'b0100, 24'h000804, 16'h5a7f})
    rq(pdasc_pkg::OP_PUSH, 16'h0, 16'h2222, 1'b0);
    `CHK(flg, 4'b0001)
    rd(4'h3);
    `CHK(rdv, 16'h0806)
    foreach (pd[i])
    begin
      rq(pdasc_pkg::OP_POP, 16'h0, 16'h0, 1'b0);
      `CHK({flg, lastAddr, lastData}, {4'b1000, 24'h000804 - 24'(2 * i), pd[i]})
    end
    rq(pdasc_pkg::OP_POP, 16'h0, 16'h0, 1'b0);
    `CHK(flg, 4'b0001)
    wr(4'h3, 16'h0700);
    wr(4'h2, 16'hfffe);
    rq(pdasc_pkg::OP_PUSH, 16'h0, 16'h3333, 1'b0);
    `CHK(flg, 4'b0001)
    summarize();
  end
endmodule
